// ===== design/bee_nvm_ctrl.sv
// Summary of operation
// - Latch clear: extra bits zero, array reads normally
// - Pump turns off when pump-on clears
// - Array read with latch set returns FF
// - Erase ignores written data, uses address only
// - Erased byte is FF, programming clears bits to 0
// - Array accesses fail while operation runs
// - Other addresses ignored after capture
// - Options byte copied to latches at reset
// - Low 32 bytes open; upper protected when bit zero
// - Protect is bit 1, effective after reset
// - Protect zero written only with latch set
// - Lock bit zero blocks test mode entry
// - Self-check entry erases whole array
// - Lock bit change waits for reset
// - STOP forces read mode, pump off
// - WAIT leaves array and pump alone
// - Pump clocked from RC oscillator when selected
// - Control bits 0..3, upper zero, reset zero
// - Latch clear clears erase and pump; STOP too
// - Pump needs capture; erase select frozen
// - Write with latch, no pump, captures target
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module bee_nvm_ctrl
  import bee_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [BEE_ADDR_W-1:0] s_axi_awaddr_in,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [BEE_ADDR_W-1:0] s_axi_araddr_in,
  // AXI4-Lite read data
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // Low-power modes and test entry
  input wire logic stop_mode_in,
  input wire logic self_check_entry_in,
  input wire logic test_mode_req_in,
  output logic test_mode_grant_out,
  // Charge pump and clock output
  input wire logic rc_osc_select_in,
  output logic pump_on_out,
  output logic pump_clk_rc_out,
  output logic cpu_clock_output_out
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic pump_on; // Charge pump enable bit
  logic array_latch_enable; // Sequence latch bit
  logic erase_select; // Erase rather than program
  logic clk_out_en; // Clock output bit
  logic captured; // Target address held
  logic [7:0] cap_addr; // Captured byte address
  logic [7:0] cap_data; // Captured program data
  logic prot_open; // Latched protect bit, 1 = open
  logic content_lock; // Latched lock bit, 0 = locked
  logic [7:0] mem [BEE_ARRAY_DEPTH]; // Array storage
  logic aw_held; // Write address taken
  logic w_held; // Write data taken
  logic [9:0] aw_idx; // Held write word index
  logic [7:0] w_byte; // Held write data byte
  logic w_lane0; // Held strobe of byte lane 0
  logic wr_go; // Write performed this cycle
  logic wr_ctrl; // Write hits control register
  logic wr_arr; // Write hits array
  logic capture; // Capture target this cycle
  logic commit; // Operation ends this cycle
  logic ar_go; // Read taken this cycle
  logic [9:0] ar_idx; // Read word index
  logic [31:0] next_rdata; // Read data to register
  logic [1:0] next_rresp; // Read response to register
  logic [1:0] next_bresp; // Write response to register

  ////////////////////////////////////////////////////////////////////////
  // Write channel handshakes
  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
  assign wr_go = aw_held && w_held && !s_axi_bvalid_out;
  assign wr_ctrl = wr_go && w_lane0 && (aw_idx == BEE_CTRL_IDX);
  assign wr_arr = aw_idx[9:8] == BEE_ARRAY_PAGE;

  // Address and data taken in either order
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 10'h000;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      // Take address
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr_in[11:2];
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      // Take data
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata_in[7:0];
        w_lane0 <= s_axi_wstrb_in[0];
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response selection
  always_comb begin
    next_bresp = BEE_RESP_OKAY;
    if (aw_idx == BEE_CTRL_IDX) begin
      next_bresp = BEE_RESP_OKAY;
    end else if (!wr_arr) begin
      next_bresp = BEE_RESP_DECERR;
    end else if (pump_on) begin
      next_bresp = BEE_RESP_SLVERR;
    end else if (array_latch_enable && !captured && !prot_open &&
                 aw_idx[7:0] > BEE_OPEN_LAST) begin
      next_bresp = BEE_RESP_SLVERR;
    end
  end

  // Response stands until bready
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= BEE_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= next_bresp;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register
  // Commit on software clear of latch with pump on; STOP aborts
  assign commit = wr_ctrl && !w_byte[BEE_LATCH_BIT] && pump_on &&
                  !stop_mode_in;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      {clk_out_en, erase_select, array_latch_enable, pump_on} <=
        BEE_CTRL_RESET;
    end else begin
      // Clock output bit untouched by STOP
      if (wr_ctrl) begin
        clk_out_en <= w_byte[BEE_CLKOUT_BIT];
      end
      if (stop_mode_in) begin
        // Read mode, pump off
        array_latch_enable <= 1'b0;
        erase_select <= 1'b0;
        pump_on <= 1'b0;
      end else if (wr_ctrl) begin
        array_latch_enable <= w_byte[BEE_LATCH_BIT];
        if (!w_byte[BEE_LATCH_BIT]) begin
          // Clearing latch clears erase and pump
          erase_select <= 1'b0;
          pump_on <= 1'b0;
        end else begin
          // Erase select frozen once captured
          if (!captured) begin
            erase_select <= w_byte[BEE_ERASE_BIT];
          end
          // Pump needs capture and stays set
          if (captured && w_byte[BEE_PUMP_BIT]) begin
            pump_on <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Target capture
  // Protect zero can only land through this latched sequence
  assign capture = wr_go && w_lane0 && wr_arr && array_latch_enable &&
                   !pump_on && !captured && !stop_mode_in &&
                   (prot_open || aw_idx[7:0] <= BEE_OPEN_LAST);

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      captured <= 1'b0;
      cap_addr <= 8'h00;
      cap_data <= 8'h00;
    end else if (stop_mode_in || (wr_ctrl && !w_byte[BEE_LATCH_BIT])) begin
      // New sequence needs latch cleared first
      captured <= 1'b0;
    end else if (capture) begin
      captured <= 1'b1;
      cap_addr <= aw_idx[7:0];
      cap_data <= w_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array storage, one entry per generate step
  // Contents survive reset; self-check entry blanks everything
  for (genvar i = 0; i < BEE_ARRAY_DEPTH; i++) begin : g_cell
    always_ff @(posedge clk_sys_in) begin
      if (self_check_entry_in) begin
        mem[i] <= BEE_ERASED;
      end else if (commit && cap_addr == 8'(i)) begin
        if (erase_select) begin
          // Erase uses address only
          mem[i] <= BEE_ERASED;
        end else begin
          // Program only pulls bits to zero
          mem[i] <= mem[i] & cap_data;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Options latches, loaded only at reset
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      prot_open <= mem[0][BEE_OPT_PROT_BIT];
      content_lock <= mem[0][BEE_OPT_LOCK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign ar_go = s_axi_arvalid_in && s_axi_arready_out;
  assign ar_idx = s_axi_araddr_in[11:2];

  // Read data selection
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = BEE_RESP_OKAY;
    if (ar_idx == BEE_CTRL_IDX) begin
      // Upper four bits read zero
      next_rdata[3:0] = {clk_out_en, erase_select, array_latch_enable,
                         pump_on};
    end else if (ar_idx[9:8] == BEE_ARRAY_PAGE) begin
      if (array_latch_enable) begin
        next_rdata[7:0] = BEE_BUSY_READ;
        if (pump_on) begin
          next_rresp = BEE_RESP_SLVERR;
        end
      end else begin
        next_rdata[7:0] = mem[ar_idx[7:0]];
      end
    end else begin
      next_rresp = BEE_RESP_DECERR;
    end
  end

  // Read data stands until rready
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= BEE_RESP_OKAY;
    end else if (ar_go) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= next_rdata;
      s_axi_rresp_out <= next_rresp;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; WAIT has no path here, so operations run on
  assign pump_on_out = pump_on;
  assign pump_clk_rc_out = pump_on && rc_osc_select_in;
  assign cpu_clock_output_out = clk_out_en;
  assign test_mode_grant_out = test_mode_req_in && content_lock;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  a_read_mode_clear: assert property (
    !array_latch_enable |-> !erase_select && !pump_on)
    else $error("erase or pump set in read mode");

  a_pump_follows: assert property (
    !pump_on |-> !pump_on_out && !pump_clk_rc_out)
    else $error("pump left running");

  a_busy_read_ff: assert property (
    ar_go && ar_idx[9:8] == BEE_ARRAY_PAGE && array_latch_enable
    |=> s_axi_rvalid_out && s_axi_rdata_out[7:0] == BEE_BUSY_READ)
    else $error("array read during sequence not FF");

  a_erase_blank: assert property (
    commit && erase_select |=> mem[cap_addr] == BEE_ERASED)
    else $error("erased byte not FF");

  a_busy_refused: assert property (
    wr_go && wr_arr && pump_on
    |=> s_axi_bvalid_out && s_axi_bresp_out == BEE_RESP_SLVERR)
    else $error("array write accepted during operation");

  a_capture_lock: assert property (
    captured && !commit && !stop_mode_in && !wr_ctrl
    |=> captured && $stable(cap_addr) && $stable(cap_data))
    else $error("captured target changed");

  a_protect_block: assert property (
    captured |-> prot_open || cap_addr <= BEE_OPEN_LAST)
    else $error("protected byte captured");

  a_test_lock: assert property (
    !content_lock |-> !test_mode_grant_out)
    else $error("test mode granted while locked");

  a_stop_read: assert property (
    stop_mode_in |=> !array_latch_enable && !pump_on && !captured)
    else $error("STOP left sequence active");

  a_pump_hold: assert property (
    $rose(pump_on) |-> $past(captured) ##1
    (pump_on || !array_latch_enable))
    else $error("pump set without capture or cleared early");

  // Two reset edges in a row, so the first load after power-up is skipped
  a_opt_latch: assert property (
    disable iff (1'b0)
    sys_rst_in [*2] |=>
    prot_open == $past(mem[0][BEE_OPT_PROT_BIT]) &&
    content_lock == $past(mem[0][BEE_OPT_LOCK_BIT]))
    else $error("options not latched at reset");

endmodule // bee_nvm_ctrl
`default_nettype wire

// ===== design/bee_pkg.sv
`default_nettype none
package bee_pkg;
  // Word indices of the registers; byte address is four times the index
  localparam logic [9:0] BEE_CTRL_IDX = 10'h007;
  localparam logic [9:0] BEE_OPT_IDX = 10'h100;
  localparam logic [1:0] BEE_ARRAY_PAGE = 2'h1;
  // Bus width and array depth
  localparam int BEE_ADDR_W = 12;
  localparam int BEE_ARRAY_DEPTH = 256;
  // Control register field positions
  localparam int BEE_PUMP_BIT = 0;
  localparam int BEE_LATCH_BIT = 1;
  localparam int BEE_ERASE_BIT = 2;
  localparam int BEE_CLKOUT_BIT = 3;
  localparam logic [3:0] BEE_CTRL_RESET = 4'h0;
  // Options byte field positions
  localparam int BEE_OPT_LOCK_BIT = 0;
  localparam int BEE_OPT_PROT_BIT = 1;
  // Array values
  localparam logic [7:0] BEE_ERASED = 8'hFF;
  localparam logic [7:0] BEE_BUSY_READ = 8'hFF;
  // Highest byte that can never be protected
  localparam logic [7:0] BEE_OPEN_LAST = 8'h1F;
  // Bus responses
  localparam logic [1:0] BEE_RESP_OKAY = 2'h0;
  localparam logic [1:0] BEE_RESP_SLVERR = 2'h2;
  localparam logic [1:0] BEE_RESP_DECERR = 2'h3;
endpackage
`default_nettype wire

// ===== tb/byte_eeprom_program_erase_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module byte_eeprom_program_erase_control_test;
  import bee_pkg::*;
  // Clock, reset and bus drives
  logic clk_sys_in = 0;
  logic sys_rst_in = 1;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat;
  logic [3:0] ws = 4'hF;
  logic awr, wrdy, bv, arr, rv, pump, prc, clko, grant;
  logic [1:0] bresp, rresp;
  logic stop = 0, treq = 0, rcs = 0;
  logic scheck = 1; // Array wiped from time zero, options byte defined
  int n_errors = 0, checked = 0;
  int u, l;
  logic [7:0] d;
  localparam logic [11:0] ctrl_a = {BEE_CTRL_IDX, 2'h0};
  always #50 clk_sys_in = ~clk_sys_in;
  ////////////////////////////////////////////////////////////////////
  bee_nvm_ctrl u_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bry), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rry), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rresp), .stop_mode_in(stop),
    .self_check_entry_in(scheck), .test_mode_req_in(treq),
    .test_mode_grant_out(grant), .rc_osc_select_in(rcs),
    .pump_on_out(pump), .pump_clk_rc_out(prc),
    .cpu_clock_output_out(clko));
  ////////////////////////////////////////////////////////////////////
  // Byte address of array byte i
  function automatic logic [11:0] abyte(input int i);
    return {BEE_OPT_IDX, 2'h0} + 12'(4 * i);
  endfunction
  // Programming can only clear bits
  function automatic logic [7:0] prog(input logic [7:0] o,
                                      input logic [7:0] n);
    return o & n;
  endfunction
  // Compare and count
  task automatic chk(input string s, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
  endtask
  // Bus write, both channels offered together
  task automatic wr(input logic [11:0] a, input logic [7:0] dv,
                    input logic [1:0] er);
    logic pa, pw;
    awa <= a;
    wd <= {24'h0, dv};
    awv <= 1'b1;
    wv <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(posedge clk_sys_in);
      if (pa && awr) awv <= 1'b0;
      if (pw && wrdy) wv <= 1'b0;
      pa = pa && !awr;
      pw = pw && !wrdy;
    end
    bry <= 1'b1;
    do @(posedge clk_sys_in); while (bv !== 1'b1);
    bry <= 1'b0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask
  // Bus read with data and response compare
  task automatic rdc(input logic [11:0] a, input logic [7:0] ed,
                     input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk_sys_in); while (arr !== 1'b1);
    arv <= 1'b0;
    rry <= 1'b1;
    do @(posedge clk_sys_in); while (rv !== 1'b1);
    rry <= 1'b0;
    chk("rdata", rdat, 32'(ed));
    chk("rresp", 32'(rresp), 32'(er));
  endtask
  // Synchronous reset for 16 cycles
  task automatic rst;
    sys_rst_in <= 1'b1;
    repeat (16) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  // One program or erase sequence with checks while busy
  task automatic op(input logic [7:0] cf, input int i, input logic [7:0] dv);
    wr(ctrl_a, cf, BEE_RESP_OKAY);
    wr(abyte(i), dv, BEE_RESP_OKAY);
    rdc(abyte(i), BEE_BUSY_READ, BEE_RESP_OKAY);
    wr(ctrl_a, cf | 8'h05, BEE_RESP_OKAY);
    rdc(ctrl_a, cf | 8'h01, BEE_RESP_OKAY);
    chk("pump_clk", 32'(prc), 32'(rcs));
    rdc(abyte(i), BEE_BUSY_READ, BEE_RESP_SLVERR);
    wr(abyte(i), 8'h00, BEE_RESP_SLVERR);
    wr(ctrl_a, 8'h00, BEE_RESP_OKAY);
    chk("pump", 32'(pump), 32'h0);
  endtask
  // Verdict
  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (30000) @(posedge clk_sys_in);
    n_errors++;
    end_of_test();
  end
  // Main sequence
  initial begin
    void'($urandom(16));
    rst();
    rdc(ctrl_a, 8'h00, BEE_RESP_OKAY);
    // Self-check entry wipes the array, then latch options
    scheck <= 1'b1;
    @(posedge clk_sys_in);
    scheck <= 1'b0;
    rst();
    treq <= 1'b1;
    u = 32 + int'($urandom % 224);
    l = 1 + int'($urandom % 30); // Keeps l + 1 in the open part
    @(posedge clk_sys_in);
    chk("grant", 32'(grant), 32'h1);
    rdc(abyte(u), BEE_ERASED, BEE_RESP_OKAY);
    // Latch clear keeps erase and pump low
    wr(ctrl_a, 8'hF5, BEE_RESP_OKAY);
    rdc(ctrl_a, 8'h00, BEE_RESP_OKAY);
    wr(ctrl_a, 8'h03, BEE_RESP_OKAY);
    rdc(ctrl_a, 8'h02, BEE_RESP_OKAY);
    wr(ctrl_a, 8'h00, BEE_RESP_OKAY);
    wr(abyte(0), 8'h00, BEE_RESP_OKAY);
    rdc(abyte(0), BEE_ERASED, BEE_RESP_OKAY);
    // Random program then erase of upper bytes
    repeat (4) begin
      d = 8'($urandom);
      rcs <= 1'($urandom);
      u = 32 + int'($urandom % 224);
      op(8'h02, u, d);
      rdc(abyte(u), prog(BEE_ERASED, d), BEE_RESP_OKAY);
      op(8'h06, u, d);
      rdc(abyte(u), BEE_ERASED, BEE_RESP_OKAY);
    end
    op(8'h02, u, 8'h00);
    rdc(abyte(u), 8'h00, BEE_RESP_OKAY);
    // Second address after capture is ignored
    wr(ctrl_a, 8'h02, BEE_RESP_OKAY);
    wr(abyte(l), 8'h00, BEE_RESP_OKAY);
    wr(abyte(l + 1), 8'h00, BEE_RESP_OKAY);
    wr(ctrl_a, 8'h03, BEE_RESP_OKAY);
    wr(ctrl_a, 8'h00, BEE_RESP_OKAY);
    rdc(abyte(l + 1), BEE_ERASED, BEE_RESP_OKAY);
    rdc(abyte(l), 8'h00, BEE_RESP_OKAY);
    // Strobe off drops the write
    ws <= 4'h0;
    wr(ctrl_a, 8'h08, BEE_RESP_OKAY);
    ws <= 4'hF;
    rdc(ctrl_a, 8'h00, BEE_RESP_OKAY);
    // STOP aborts an erase, clock output kept
    wr(ctrl_a, 8'h0E, BEE_RESP_OKAY);
    chk("clk_out", 32'(clko), 32'h1);
    wr(abyte(u), 8'h00, BEE_RESP_OKAY);
    wr(ctrl_a, 8'h0F, BEE_RESP_OKAY);
    stop <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk("pump", 32'(pump), 32'h0);
    stop <= 1'b0;
    rdc(ctrl_a, 8'h08, BEE_RESP_OKAY);
    rdc(abyte(u), 8'h00, BEE_RESP_OKAY);
    // Unmapped place
    rdc(12'h020, 8'h00, BEE_RESP_DECERR);
    wr(12'h024, 8'h00, BEE_RESP_DECERR);
    // Clear protect and lock; effect waits for reset
    op(8'h02, 0, 8'hFC);
    chk("grant", 32'(grant), 32'h1);
    op(8'h06, u, 8'h00);
    rdc(abyte(u), BEE_ERASED, BEE_RESP_OKAY);
    rst();
    chk("grant", 32'(grant), 32'h0);
    wr(ctrl_a, 8'h02, BEE_RESP_OKAY);
    wr(abyte(u), 8'h00, BEE_RESP_SLVERR);
    wr(abyte(31), 8'h00, BEE_RESP_OKAY);
    wr(ctrl_a, 8'h03, BEE_RESP_OKAY);
    wr(ctrl_a, 8'h00, BEE_RESP_OKAY);
    rdc(abyte(u), BEE_ERASED, BEE_RESP_OKAY);
    rdc(abyte(31), 8'h00, BEE_RESP_OKAY);
    end_of_test();
  end
endmodule // byte_eeprom_program_erase_control_test
`default_nettype wire
